/* inc/pcp_pkg.sv */
// shared constants and types of the printer parallel command port
// assumes a single 50 MHz clock domain and pins sampled on that clock
`default_nettype none
package pcp_pkg;
  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int          CLK_MHZ      = 50;
  localparam int          BUSY_MIN_US  = 20;
  localparam int          BUSY_CYC     = BUSY_MIN_US * CLK_MHZ;
  localparam int          HOLD_W       = 10;
  localparam logic [9:0]  HOLD_LAST    = 10'(BUSY_CYC - 1);
  // ----------------------------------------------------------------------
  // data bus layout (bit 0 carries the half-step weight)
  // ----------------------------------------------------------------------
  localparam int          DATA_W       = 13;
  localparam int          GLYPH_LSB    = 1;
  localparam int          GLYPH_W      = 7;
  localparam int          HEAD_W       = 11;
  localparam int          FEED_LSB     = 1;
  localparam int          FEED_W       = 10;
  localparam int          DIR_BIT      = 11;
  localparam int          EXT_BIT      = 12;
  localparam int          FORM_LSB     = 8;
  localparam int          FORM_W       = 4;
  localparam int          AMOUNT_W     = 12;
  localparam logic [6:0]  GLYPH_FF     = 7'h0C;
  localparam logic [3:0]  FORM_DEFAULT = 4'h0;
  // ----------------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------------
  localparam int          ADDR_W       = 2;
  localparam int          REG_W        = 8;
  localparam logic [1:0]  ADDR_CONFIG  = 2'h0;
  localparam logic [1:0]  ADDR_STATUS  = 2'h1;
  localparam int          CFG_WIDE     = 0;
  localparam int          CFG_SPLIT    = 1;
  localparam logic [7:0]  CONFIG_RST   = 8'h00;
  localparam int          ST_FAULT     = 0;
  localparam int          ST_FULL      = 1;
  localparam int          ST_OK        = 2;
  localparam int          ST_HOMING    = 3;
  localparam int          ST_FORM_LSB  = 4;
  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    K_GLYPH  = 3'b000,
    K_HEAD   = 3'b001,
    K_FEED_R = 3'b010,
    K_FEED_L = 3'b011,
    K_FORM   = 3'b100
  } pcp_kind_e;
  typedef enum logic [1:0] {
    S_IDLE   = 2'b00,
    S_HOLD   = 2'b01,
    S_DRAIN  = 2'b10,
    S_HOMING = 2'b11
  } pcp_state_e;
  typedef struct packed {
    pcp_kind_e             kind;
    logic                  dir;
    logic [AMOUNT_W-1:0]   amount;
    logic [GLYPH_W-1:0]    glyph;
    logic [FORM_W-1:0]     form_code;
  } pcp_cmd_s;
endpackage
`default_nettype wire

/* hw/pcp_port.sv */
// parallel command port of a serial impact printer: pin side toward the
// host, single-entry command buffer toward the mechanism controller
// assumes all pins are synchronous to CLK and the mechanism drains the
// buffer with CMD_READY and reports homing and malfunctions by level/pulse
//
// Contract
// RQ1 - all port lines are active low
// RQ2 - interface disabled unless unit select low
// RQ3 - restore homes, resets logic, clears fault
// RQ4 - one bus word per command, strobe-typed
// RQ5 - character uses seven low bits only; the code takes the character from data bits 7:1
// RQ6 - carriage distance eleven low bits, half steps
// RQ7 - carriage direction bit: zero right, one left
// RQ8 - wide variant adds extended bit as 1024
// RQ9 - feed count ten bits, 1/48 inch
// RQ10 - feed direction bit: zero up, one down
// RQ11 - character strobe captures data into buffer
// RQ12 - carriage strobe captures carriage command
// RQ13 - ribbon raised while lift line low
// RQ14 - main feed strobe: single or right platen
// RQ15 - auxiliary feed strobe: left platen
// RQ16 - form advance uses programmed form length
// RQ17 - form-feed character programs four length bits
// RQ18 - default length eleven inches until programmed
// RQ19 - host sends form-feed pattern in low bits; the code matches it on data bits 7:1
// RQ20 - three accept-ok outputs driven identically
// RQ21 - strobes ignored while accept-ok deasserted
// RQ22 - busy 20 to 800 us, longer if full
// RQ23 - faulted port refuses commands until restore
// RQ24 - host holds data stable during strobe
`default_nettype none
module pcp_port
  import pcp_pkg::*;
(
  input  wire logic                CLK,
  input  wire logic                ARST_N,
  input  wire logic [DATA_W-1:0]   DATA_N,
  input  wire logic                GLYPH_LOAD_N,
  input  wire logic                HEAD_MOVE_LOAD_N,
  input  wire logic                PRIMARY_FEED_LOAD_N,
  input  wire logic                SECONDARY_FEED_LOAD_N,
  input  wire logic                FORM_START_ADVANCE_N,
  input  wire logic                INK_BAND_RAISE_N,
  input  wire logic                RESTORE_N,
  input  wire logic                UNIT_SELECT_N,
  output logic                     CMD_ACCEPT_OK_A_N,
  output logic                     CMD_ACCEPT_OK_B_N,
  output logic                     CMD_ACCEPT_OK_C_N,
  output logic                     PRINTER_READY_N,
  output logic                     FAULT_FLAG_N,
  output logic                     IF_OE,
  output logic                     RIBBON_RAISE,
  output logic                     HOME_REQ,
  input  wire logic                MECH_HOME_DONE,
  input  wire logic                MECH_FAULT,
  output logic                     CMD_VALID,
  output pcp_cmd_s                 CMD,
  input  wire logic                CMD_READY,
  input  wire logic [ADDR_W-1:0]   REG_ADDR,
  input  wire logic [REG_W-1:0]    REG_WDATA,
  input  wire logic                REG_WR,
  input  wire logic                REG_RD,
  output logic [REG_W-1:0]         REG_RDATA
);

  // ----------------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------------
  logic [1:0] rst_sync;
  logic       rst_n;

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // ----------------------------------------------------------------------
  // pin decode
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] data;
  logic [4:0]        strobe;
  logic [4:0]        strobe_q;
  logic [4:0]        strobe_fall;
  logic              restore_q;
  logic              restore_fall;
  logic              sel;
  logic              any_fall;
  logic              accept;
  logic [REG_W-1:0]  config_r;
  logic              fault;
  logic              ok_int;
  pcp_state_e        state;
  logic [HOLD_W-1:0] hold_cnt;
  logic [FORM_W-1:0] form_code;

  assign data   = ~DATA_N;                                 // see RQ1
  assign sel    = ~UNIT_SELECT_N;                          // see RQ1
  assign strobe = ~{FORM_START_ADVANCE_N, SECONDARY_FEED_LOAD_N,
                    PRIMARY_FEED_LOAD_N, HEAD_MOVE_LOAD_N,
                    GLYPH_LOAD_N};                         // see RQ1

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strobe_q  <= 5'h00;
      restore_q <= 1'b0;
    end
    else
    begin
      strobe_q  <= strobe;
      restore_q <= ~RESTORE_N;
    end
  end

  // deselected pins are still sampled, but give no strobe or restore edge
  assign strobe_fall  = sel ? (strobe & ~strobe_q) : 5'h00; // see RQ2
  assign restore_fall = sel & ~RESTORE_N & ~restore_q;      // see RQ2
  assign any_fall     = |strobe_fall;
  // a strobe without the split platen fitted still counts as a pulse
  assign ok_int = (state == S_IDLE) && !fault;              // see RQ23
  assign accept = any_fall && ok_int && !restore_fall;      // see RQ21

  // ----------------------------------------------------------------------
  // command capture
  // ----------------------------------------------------------------------
  pcp_cmd_s next_cmd;
  logic     ext;

  always_comb
  begin
    ext                = config_r[CFG_WIDE] & data[EXT_BIT];  // see RQ8
    next_cmd           = '0;
    next_cmd.form_code = form_code;
    next_cmd.dir       = data[DIR_BIT];                     // see RQ7
    if (strobe_fall[0])
    begin
      next_cmd.kind  = K_GLYPH;                             // see RQ11
      next_cmd.glyph = data[GLYPH_LSB +: GLYPH_W];          // see RQ5
    end
    else if (strobe_fall[1])
    begin
      next_cmd.kind   = K_HEAD;                             // see RQ12
      next_cmd.amount = {ext, data[HEAD_W-1:0]};            // see RQ6
    end
    else if (strobe_fall[2] || strobe_fall[3])
    begin
      // see RQ14
      // see RQ15
      next_cmd.kind = (strobe_fall[3] && config_r[CFG_SPLIT]) ?
                      K_FEED_L : K_FEED_R;
      next_cmd.amount = {2'b00, data[FEED_LSB +: FEED_W]};  // see RQ9
      // dir already set from the same bit                  // see RQ10
    end
    else
    begin
      next_cmd.kind = K_FORM;                               // see RQ16
    end
  end

  // one-entry buffer: only refilled when empty, so set and clear never meet
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      CMD_VALID <= 1'b0;
      CMD       <= '0;
    end
    else if (restore_fall)
      CMD_VALID <= 1'b0;                                    // see RQ3
    else if (accept)
    begin
      CMD_VALID <= 1'b1;                                    // see RQ4
      CMD       <= next_cmd;
    end
    else if (CMD_READY)
      CMD_VALID <= 1'b0;
  end

  // form length programming through the form-feed character
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      form_code <= FORM_DEFAULT;                            // see RQ18
    else if (restore_fall)
      form_code <= FORM_DEFAULT;                            // see RQ18
    else if (accept && strobe_fall[0] &&
             data[GLYPH_LSB +: GLYPH_W] == GLYPH_FF)
      form_code <= data[FORM_LSB +: FORM_W];                // see RQ17
  end

  // ----------------------------------------------------------------------
  // accept handshake
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state    <= S_IDLE;
      hold_cnt <= '0;
    end
    else if (restore_fall)
      state <= S_HOMING;                                    // see RQ3
    else
    begin
      case (state)
        S_IDLE:
          if (accept)
          begin
            state    <= S_HOLD;                             // see RQ22
            hold_cnt <= '0;
          end
        S_HOLD:
          if (hold_cnt == HOLD_LAST)
            state <= S_DRAIN;
          else
            hold_cnt <= hold_cnt + 10'h001;
        S_DRAIN:
          if (!CMD_VALID)
            state <= S_IDLE;                                // see RQ22
        S_HOMING:
          if (MECH_HOME_DONE)
            state <= S_IDLE;
        default:
          state <= S_IDLE;
      endcase
    end
  end

  // malfunction stays latched; it outlasts a restore while still present
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      fault <= 1'b0;
    else if (MECH_FAULT)
      fault <= 1'b1;
    else if (restore_fall)
      fault <= 1'b0;                                        // see RQ3
  end

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      HOME_REQ <= 1'b0;
    else
      HOME_REQ <= restore_fall;                             // see RQ3
  end

  // ----------------------------------------------------------------------
  // pin outputs
  // ----------------------------------------------------------------------
  logic [2:0] ok_n;

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ok_n            <= 3'h7;
      PRINTER_READY_N <= 1'b1;
      FAULT_FLAG_N    <= 1'b1;
      IF_OE           <= 1'b0;
      RIBBON_RAISE    <= 1'b0;
    end
    else
    begin
      // the next-cycle ok already reflects this cycle's accept
      ok_n <= {3{~(sel && ok_int && !accept && !restore_fall)}};
      // see RQ20
      PRINTER_READY_N <= ~(sel && !fault && state != S_HOMING);
      FAULT_FLAG_N    <= ~(sel && fault);                   // see RQ2
      IF_OE           <= sel;                               // see RQ2
      RIBBON_RAISE    <= sel && !INK_BAND_RAISE_N;          // see RQ13
    end
  end

  assign CMD_ACCEPT_OK_A_N = ok_n[0];
  assign CMD_ACCEPT_OK_B_N = ok_n[1];
  assign CMD_ACCEPT_OK_C_N = ok_n[2];

  // ----------------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      config_r <= CONFIG_RST;
    else if (REG_WR && REG_ADDR == ADDR_CONFIG)
      config_r <= REG_WDATA;
  end

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      REG_RDATA <= '0;
    else if (REG_RD && REG_ADDR == ADDR_CONFIG)
      REG_RDATA <= config_r;
    else if (REG_RD && REG_ADDR == ADDR_STATUS)
    begin
      REG_RDATA              <= '0;
      REG_RDATA[ST_FAULT]    <= fault;
      REG_RDATA[ST_FULL]     <= CMD_VALID;
      REG_RDATA[ST_OK]       <= ok_int;
      REG_RDATA[ST_HOMING]   <= state == S_HOMING;
      REG_RDATA[ST_FORM_LSB +: FORM_W] <= form_code;
    end
    else
      REG_RDATA <= '0;
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);

  ok_trio_same_a: assert property ( // see RQ20
    CMD_ACCEPT_OK_A_N == CMD_ACCEPT_OK_B_N &&
    CMD_ACCEPT_OK_B_N == CMD_ACCEPT_OK_C_N)
    else $error("accept-ok outputs differ");
  deselect_quiet_a: assert property ( // see RQ2
    UNIT_SELECT_N |=> !IF_OE && CMD_ACCEPT_OK_A_N && FAULT_FLAG_N)
    else $error("outputs active while deselected");
  busy_hold_a: assert property ( // see RQ22
    (state == S_HOLD && hold_cnt < HOLD_LAST) |=> CMD_ACCEPT_OK_A_N)
    else $error("accept-ok returned before minimum busy time");
  accept_drops_ok_a: assert property ( // see RQ22
    accept |=> CMD_ACCEPT_OK_A_N [*8])
    else $error("accept-ok not withdrawn after strobe");
  busy_ignore_a: assert property ( // see RQ21
    (any_fall && !ok_int) |=> !$rose(CMD_VALID))
    else $error("strobe taken while busy");
  glyph_code_a: assert property ( // see RQ5
    (accept && strobe_fall[0]) |=> CMD.kind == K_GLYPH &&
      CMD.glyph == $past(data[GLYPH_LSB +: GLYPH_W]))
    else $error("character code wrong");
  head_dir_a: assert property ( // see RQ7
    (accept && strobe_fall[1]) |=> CMD.kind == K_HEAD &&
      CMD.dir == $past(data[DIR_BIT]) &&
      CMD.amount[HEAD_W-1:0] == $past(data[HEAD_W-1:0]))
    else $error("carriage command wrong");
  feed_count_a: assert property ( // see RQ9
    (accept && strobe_fall[2]) |=> CMD.kind == K_FEED_R &&
      CMD.amount[FEED_W-1:0] == $past(data[FEED_LSB +: FEED_W]))
    else $error("feed count wrong");
  fault_refuse_a: assert property ( // see RQ23
    fault |-> !accept)
    else $error("command taken while faulted");
  restore_clear_a: assert property ( // see RQ3
    restore_fall |=> !CMD_VALID && HOME_REQ && form_code == FORM_DEFAULT)
    else $error("restore did not reset the port");
  ribbon_level_a: assert property ( // see RQ13
    (!UNIT_SELECT_N && !INK_BAND_RAISE_N) |=> RIBBON_RAISE)
    else $error("ribbon not raised");

  glyph_taken_c: cover property (accept && strobe_fall[0]);
  drain_wait_c:  cover property (state == S_DRAIN && CMD_VALID);
  form_prog_c:   cover property (accept && strobe_fall[0] &&
                                 data[GLYPH_LSB +: GLYPH_W] == GLYPH_FF);
  restore_c:     cover property (restore_fall && fault);

endmodule
`default_nettype wire

/* bench/pcp_host_model.sv */
// host model: drives the command bus and the five load strobes
// assumes the bench calls send() from one process, one command at a time
`default_nettype none
module pcp_host_model
  import pcp_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         ok_n,
  output logic [DATA_W-1:0] data_n,
  output logic [4:0]        stb_n
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    data_n = '1;
    stb_n  = '1;
  end

  // ----------------------------------------------------------------------
  // one command; strobe 0 glyph, 1 head, 2 main feed, 3 aux feed, 4 form
  // ----------------------------------------------------------------------
  task automatic send(input int which, input logic [DATA_W-1:0] d,
                      input bit wait_ok, output bit timed_out);
    int n;
    n = 0;
    // only one of the three ready lines is looked at
    while (wait_ok && ok_n !== 1'b0 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    timed_out = (n == 3000);
    @(posedge clk);
    data_n <= ~d;
    @(posedge clk);
    stb_n[which] <= 1'b0;
    repeat (3) @(posedge clk);
    stb_n[which] <= 1'b1;
    @(posedge clk);
    // released lines float up to the pull-ups, not the last word
    data_n <= '1;
  endtask
endmodule
`default_nettype wire

/* bench/test_printer_parallel_command_port.sv */
// self-checking bench of the printer parallel command port
// assumes pcp_pkg and the host model are compiled before this file
`default_nettype none
module test_printer_parallel_command_port
  import pcp_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;

  logic              clk, arst_n, ink_n, restore_n, sel_n, home_done;
  logic              mech_fault, cmd_ready, reg_wr, reg_rd, stall;
  logic              ok_a_n, ok_b_n, ok_c_n, ready_n, fault_n, if_oe;
  logic              ribbon, home_req, cmd_valid;
  logic [ADDR_W-1:0] reg_addr;
  logic [REG_W-1:0]  reg_wdata, reg_rdata, rd;
  logic [DATA_W-1:0] data_n;
  logic [4:0]        stb_n;
  logic [6:0]        g;
  logic [31:0]       rnd;
  pcp_cmd_s          cmd;
  pcp_cmd_s          exp_q[$];
  int                fail_count, comparisons, n;
  bit                to;

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  pcp_port uut (.CLK(clk), .ARST_N(arst_n), .DATA_N(data_n),
    .GLYPH_LOAD_N(stb_n[0]), .HEAD_MOVE_LOAD_N(stb_n[1]),
    .PRIMARY_FEED_LOAD_N(stb_n[2]), .SECONDARY_FEED_LOAD_N(stb_n[3]),
    .FORM_START_ADVANCE_N(stb_n[4]), .INK_BAND_RAISE_N(ink_n),
    .RESTORE_N(restore_n), .UNIT_SELECT_N(sel_n),
    .CMD_ACCEPT_OK_A_N(ok_a_n), .CMD_ACCEPT_OK_B_N(ok_b_n),
    .CMD_ACCEPT_OK_C_N(ok_c_n), .PRINTER_READY_N(ready_n),
    .FAULT_FLAG_N(fault_n), .IF_OE(if_oe), .RIBBON_RAISE(ribbon),
    .HOME_REQ(home_req), .MECH_HOME_DONE(home_done),
    .MECH_FAULT(mech_fault), .CMD_VALID(cmd_valid), .CMD(cmd),
    .CMD_READY(cmd_ready), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata));

  pcp_host_model host (.clk(clk), .ok_n(ok_a_n), .data_n(data_n),
    .stb_n(stb_n));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] e,
                     input logic [31:0] s);
    comparisons++;
    if (s !== e)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, e, s);
    end
  endtask

  task automatic bound(input bit ok, input string name);
    if (!ok)
    begin
      chk(name, 1, 0);
      give_verdict();
    end
  endtask

  task automatic cmp_cmd(input pcp_cmd_s e, input pcp_cmd_s s);
    chk("cmd_kind", 32'(e.kind), 32'(s.kind));
    case (e.kind)
      K_GLYPH: chk("cmd_glyph", 32'(e.glyph), 32'(s.glyph));
      K_FORM:  chk("cmd_form", 32'(e.form_code), 32'(s.form_code));
      default: chk("cmd_move", 32'({e.dir, e.amount}),
                   32'({s.dir, s.amount}));
    endcase
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  // bounded wait for accept-ok; n keeps the number of cycles waited
  task automatic wait_ready(input int lim, input string name);
    n = 0;
    while (ok_a_n !== 1'b0 && n < lim)
    begin
      cyc(1);
      n++;
    end
    bound(n < lim, name);
  endtask

  // note the expected command, then let the host send it
  task automatic put(input int which, input logic [DATA_W-1:0] d,
                     input pcp_kind_e k, input logic dir,
                     input logic [AMOUNT_W-1:0] amt, input logic [3:0] fc);
    exp_q.push_back('{kind: k, dir: dir, amount: amt, glyph: d[7:1],
                      form_code: fc});
    host.send(which, d, 1'b1, to);
    bound(!to, "ok_wait");
  endtask

  task automatic reg_write(input logic [ADDR_W-1:0] a,
                           input logic [REG_W-1:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic reg_read(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 rd = reg_rdata;
  endtask

  // ----------------------------------------------------------------------
  // mechanism side and output watcher
  // ----------------------------------------------------------------------
  always @(posedge clk)
  begin
    rnd       <= lfsr(rnd);
    cmd_ready <= rnd[0] & ~stall;
  end

  always @(posedge clk)
    if (arst_n === 1'b1)
    begin
      chk("ok_equal", {ok_a_n, ok_a_n}, {ok_b_n, ok_c_n});
      if (cmd_valid === 1'b1 && cmd_ready === 1'b1)
        if (exp_q.size() == 0)
          chk("spurious_cmd", 0, 1);
        else
          cmp_cmd(exp_q.pop_front(), cmd);
    end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    rnd = 32'h4361;
    {ink_n, restore_n, arst_n} = 3'h6;
    {sel_n, home_done, mech_fault, stall, reg_wr, reg_rd} = '0;
    {reg_addr, reg_wdata} = '0;
    {fail_count, comparisons} = '0;
    cyc(10);
    chk("ok_in_reset", 1, ok_a_n);
    chk("valid_in_reset", 0, cmd_valid);
    arst_n <= 1'b1;
    cyc(4);
    reg_read(ADDR_CONFIG);
    chk("config_reset", 32'(CONFIG_RST), 32'(rd));
    reg_read(2'h3);
    chk("unmapped_read", 0, 32'(rd));
    put(4, 13'h0000, K_FORM, 0, 0, 4'h0);
    ink_n <= 1'b0;
    cyc(3);
    chk("ribbon_up", 1, ribbon);
    ink_n <= 1'b1;
    cyc(3);
    chk("ribbon_down", 0, ribbon);
    for (int i = 0; i < 4; i++)
    begin
      g = rnd[14:8] | 7'h40;
      put(0, {rnd[20:16], g, rnd[0]}, K_GLYPH, 0, 0, 0);
    end
    put(1, 13'h1FFF, K_HEAD, 1, 12'h7FF, 0);
    put(1, 13'h0006, K_HEAD, 0, 12'h006, 0);
    put(2, 13'h0FFF, K_FEED_R, 1, 12'h3FF, 0);
    put(3, 13'h0002, K_FEED_R, 0, 12'h001, 0);
    reg_write(ADDR_CONFIG, 8'h03);
    put(1, 13'h1801, K_HEAD, 1, 12'h801, 0);
    put(3, 13'h0004, K_FEED_L, 0, 12'h002, 0);
    put(2, 13'h1003, K_FEED_R, 0, 12'h001, 0);
    for (int c = 0; c < 16; c++)
    begin
      put(0, {1'b0, 4'(c), 7'h0C, 1'b0}, K_GLYPH, 0, 0, 0);
      put(4, 13'h0000, K_FORM, 0, 0, 4'(c));
    end
    reg_read(ADDR_STATUS);
    chk("status_form", 4'hF, 32'(rd[ST_FORM_LSB +: FORM_W]));
    // a full buffer keeps the port busy past the minimum hold; the
    // mechanism is stalled only once the previous command has drained
    wait_ready(3000, "ok_idle");
    stall <= 1'b1;
    put(0, 13'h0082, K_GLYPH, 0, 0, 0);
    host.send(1, 13'h0010, 1'b0, to);
    cyc(1200);
    chk("ok_held_full", 1, ok_a_n);
    reg_read(ADDR_STATUS);
    chk("status_full", 32'(4'b0010), 32'(rd[ST_HOMING:ST_FAULT]));
    stall <= 1'b0;
    put(2, 13'h0002, K_FEED_R, 0, 12'h001, 0);
    wait_ready(40000, "ok_return");
    chk("busy_min", 1, 32'(n >= BUSY_CYC - 5));
    sel_n <= 1'b1;
    cyc(3);
    chk("oe_off", 0, if_oe);
    chk("ready_off", 1, ready_n);
    host.send(1, 13'h0010, 1'b0, to);
    sel_n <= 1'b0;
    cyc(3);
    chk("oe_on", 1, if_oe);
    mech_fault <= 1'b1;
    cyc(2);
    mech_fault <= 1'b0;
    cyc(3);
    chk("fault_shown", 0, fault_n);
    reg_read(ADDR_STATUS);
    chk("status_fault", 1, 32'(rd[ST_FAULT]));
    host.send(1, 13'h0010, 1'b0, to);
    restore_n <= 1'b0;
    cyc(1);
    #1 chk("home_req_on", 1, home_req);
    cyc(1);
    restore_n <= 1'b1;
    #1 chk("home_req_off", 0, home_req);
    cyc(4);
    home_done <= 1'b1;
    cyc(1);
    home_done <= 1'b0;
    cyc(4);
    chk("fault_cleared", 1, fault_n);
    chk("ready_back", 0, ready_n);
    put(4, 13'h0000, K_FORM, 0, 0, 4'h0);
    n = 0;
    while (exp_q.size() != 0 && n < 3000)
    begin
      cyc(1);
      n++;
    end
    bound(n < 3000, "queue_drain");
    give_verdict();
  end
endmodule
`default_nettype wire
